// ==== common/ptc_defines.svh ====
// Register offsets, field positions and reset values of the periodic timer.
// Assumes inclusion by bare name from the package and the design.
`ifndef PTC_DEFINES_SVH
`define PTC_DEFINES_SVH
`define PTC_ADDR_W 3
`define PTC_OFF_CTRL0 3'h0
`define PTC_OFF_CTRL1 3'h1
`define PTC_OFF_CMPA_LO 3'h2
`define PTC_OFF_CMPA_HI 3'h3
`define PTC_OFF_PER_LO 3'h4
`define PTC_OFF_PER_HI 3'h5
`define PTC_OFF_STATUS 3'h6
`define PTC_OFF_CNT_LO 3'h7
`define PTC_CTRL0_EN_BIT 3
`define PTC_CTRL0_TRIG_BIT 0
`define PTC_STAT_AF_BIT 0
`define PTC_STAT_PF_BIT 1
`define PTC_MODE_CMP 2'h0
`define PTC_MODE_PWM 2'h2
`define PTC_MODE_TMR 2'h3
`define PTC_FUNC_PWM 2'h2
`define PTC_FUNC_PULSE 2'h3
`define PTC_RST_BYTE 8'h00
`define PTC_CNT_MAX 10'h3FF
`endif

// ==== common/ptc_pkg.sv ====
// Types of the periodic timer block.
// Assumes ptc_defines.svh is on the include path.
`include "ptc_defines.svh"
package ptc_pkg;
  typedef struct packed {
    logic [`PTC_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ptc_bus_t;
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] func;
    logic init_lvl;
    logic invert;
    logic clr_sel;
  } ptc_ctrl_t;
  typedef enum logic [3:0] {
    PTC_S_CMP = 4'h1,
    PTC_S_TMR = 4'h2,
    PTC_S_PWM = 4'h4,
    PTC_S_PULSE = 4'h8
  } ptc_mode_t;
endpackage

// ==== design/ptc_timer.sv ====
// Periodic 10-bit timer with compare A and period comparators, byte registers.
// Assumes one core clock; tick_en is a same-domain enable, trig pin is async.
//
// Summary of operation
// - Compare A is 10 bits, low/high bytes.
// - Period is 10 bits, low/high bytes.
// - High bytes read bits 7..2 as zero.
// - Mode and function fields select compare, timer, PWM, pulse.
// - Clear-select low: period match clears, both flags.
// - Clear-select high: compare A clears, only A flag.
// - Compare A zero, clear-select high: overflow at 3FF, no flag.
// - Pin changes only on compare A flag.
// - Function field sets high, low, toggle, none.
// - Enable rise loads pin initial level.
// - Timer mode like compare, pin released.
// - PWM: period clears, A sets duty.
// - PWM period N ticks, zero gives 1024.
// - Duty at or above period is 100%.
// - PWM raises both flags on matches.
// - PWM level, force, invert controls.
// - PWM counting continues while output forced.
// - Enable or trigger edge starts single pulse.
// - Pulse ends on A match or clear.
// - Pulse ignores period and clear-select.
// - Enable rise zeroes counter; fall holds it.
// - Invert bit applies except timer mode.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/10ps
`include "ptc_defines.svh"
module ptc_timer (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire ptc_pkg::ptc_bus_t bus,
  output logic [7:0] rdata,
  input wire logic tick_en,
  input wire logic trig_pin,
  output logic out_pin,
  output logic out_oe,
  output logic compare_a_flag,
  output logic period_match_flag
);
  import ptc_pkg::*;

  logic counter_enable_q;
  logic trig_rise_sel_q;
  ptc_ctrl_t ctrl_q;
  logic [9:0] compare_a_value_q;
  logic [9:0] period_value_q;
  logic [9:0] cnt_q;
  logic en_prev_q;
  logic lvl_q;
  logic pwm_on_q;
  logic af_q;
  logic pf_q;
  logic trig_s1_q;
  logic trig_s2_q;
  logic trig_s3_q;
  logic [7:0] rdata_q;
  logic out_q;
  logic oe_q;
  ptc_mode_t mode;
  logic en_rise;
  logic trig_edge;
  logic a_hit;
  logic p_hit;
  logic clr_cnt;
  logic wr_ctrl0;
  logic af_stat_clr;
  logic pf_stat_clr;
  logic pwm_mode;

  function automatic logic [9:0] hi_merge(input logic [9:0] v, input logic [7:0] b);
    hi_merge = {b[1:0], v[7:0]};
  endfunction

  // PWM matches one count early so a period value N spans N ticks and duty N ticks
  function automatic logic [9:0] match_val(input logic [9:0] v, input logic early);
    match_val = early ? v - 10'h001 : v;
  endfunction

  always_comb begin
    unique case (ctrl_q.mode)
      `PTC_MODE_TMR: mode = PTC_S_TMR;
      `PTC_MODE_PWM: mode = (ctrl_q.func == `PTC_FUNC_PULSE) ? PTC_S_PULSE : PTC_S_PWM;
      default: mode = PTC_S_CMP;
    endcase
  end

  // The second and third synchroniser stages feed the edge detector
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      trig_s1_q <= trig_pin;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end
  assign trig_edge = trig_rise_sel_q ? (trig_s2_q & ~trig_s3_q) : (~trig_s2_q & trig_s3_q);

  assign wr_ctrl0 = bus.wr && bus.addr == `PTC_OFF_CTRL0;
  assign en_rise = counter_enable_q & ~en_prev_q;
  assign pwm_mode = mode == PTC_S_PWM;
  assign a_hit = counter_enable_q && tick_en && cnt_q == match_val(compare_a_value_q, pwm_mode)
    && compare_a_value_q != 10'h000;
  assign p_hit = counter_enable_q && tick_en && cnt_q == match_val(period_value_q, pwm_mode)
    && period_value_q != 10'h000;

  always_comb begin
    unique case (mode)
      PTC_S_PWM: clr_cnt = p_hit;
      PTC_S_PULSE: clr_cnt = 1'b0;
      default: clr_cnt = ctrl_q.clr_sel ? a_hit : p_hit;
    endcase
  end

  // Registers and the enable; a compare A match in pulse mode drops the enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_enable_q <= 1'b0;
      trig_rise_sel_q <= 1'b0;
      ctrl_q <= '0;
      compare_a_value_q <= '0;
      period_value_q <= '0;
    end else begin
      if (mode == PTC_S_PULSE && a_hit) begin
        counter_enable_q <= 1'b0;
      end else if (wr_ctrl0) begin
        counter_enable_q <= bus.wdata[`PTC_CTRL0_EN_BIT];
      end else if (mode == PTC_S_PULSE && trig_edge) begin
        counter_enable_q <= 1'b1;
      end
      if (wr_ctrl0) begin
        trig_rise_sel_q <= bus.wdata[`PTC_CTRL0_TRIG_BIT];
      end
      if (bus.wr) begin
        unique case (bus.addr)
          `PTC_OFF_CTRL1: ctrl_q <= ptc_ctrl_t'({bus.wdata[7:2], bus.wdata[0]});
          `PTC_OFF_CMPA_LO: compare_a_value_q[7:0] <= bus.wdata;
          `PTC_OFF_CMPA_HI: compare_a_value_q <= hi_merge(compare_a_value_q, bus.wdata);
          `PTC_OFF_PER_LO: period_value_q[7:0] <= bus.wdata;
          `PTC_OFF_PER_HI: period_value_q <= hi_merge(period_value_q, bus.wdata);
          default: ;
        endcase
      end
    end
  end

  // Counter: zeroed on enable rise, held while disabled, wraps at 3FF
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_prev_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      en_prev_q <= counter_enable_q;
      if (en_rise) begin
        cnt_q <= '0;
      end else if (counter_enable_q && tick_en) begin
        if (clr_cnt) begin
          cnt_q <= '0;
        end else begin
          cnt_q <= cnt_q + 10'h001;
        end
      end
    end
  end

  // Output level before polarity; PWM active while count is below duty
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= 1'b0;
      pwm_on_q <= 1'b0;
    end else begin
      if (en_rise) begin
        lvl_q <= ctrl_q.init_lvl;
        pwm_on_q <= compare_a_value_q != 10'h000;
      end else if (mode == PTC_S_CMP && a_hit) begin
        unique case (ctrl_q.func)
          2'h1: lvl_q <= 1'b0;
          2'h2: lvl_q <= 1'b1;
          2'h3: lvl_q <= ~lvl_q;
          default: ;
        endcase
      end else if (mode == PTC_S_PWM && tick_en && counter_enable_q) begin
        // Duty at or above the period never turns off inside the period
        if (p_hit || cnt_q == `PTC_CNT_MAX) begin
          pwm_on_q <= compare_a_value_q != 10'h000;
        end else if (a_hit) begin
          pwm_on_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      oe_q <= mode != PTC_S_TMR;
      unique case (mode)
        PTC_S_TMR: out_q <= 1'b0;
        PTC_S_CMP: out_q <= lvl_q ^ ctrl_q.invert;
        PTC_S_PULSE: out_q <= (counter_enable_q ? ctrl_q.init_lvl : ~ctrl_q.init_lvl)
          ^ ctrl_q.invert;
        default: begin
          unique case (ctrl_q.func)
            2'h0: out_q <= ~ctrl_q.init_lvl ^ ctrl_q.invert;
            2'h1: out_q <= ctrl_q.init_lvl ^ ctrl_q.invert;
            default: out_q <= ((pwm_on_q && counter_enable_q) ? ctrl_q.init_lvl
              : ~ctrl_q.init_lvl) ^ ctrl_q.invert;
          endcase
        end
      endcase
    end
  end

  // Sticky flags; a set in the same cycle as a clear wins
  assign af_stat_clr = bus.wr && bus.addr == `PTC_OFF_STATUS && bus.wdata[`PTC_STAT_AF_BIT];
  assign pf_stat_clr = bus.wr && bus.addr == `PTC_OFF_STATUS && bus.wdata[`PTC_STAT_PF_BIT];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      af_q <= 1'b0;
      pf_q <= 1'b0;
    end else begin
      if (a_hit) begin
        af_q <= 1'b1;
      end else if (af_stat_clr) begin
        af_q <= 1'b0;
      end
      if (p_hit && mode != PTC_S_PULSE && (mode == PTC_S_PWM || !ctrl_q.clr_sel)) begin
        pf_q <= 1'b1;
      end else if (pf_stat_clr) begin
        pf_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= `PTC_RST_BYTE;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `PTC_OFF_CTRL0: rdata_q <= {4'h0, counter_enable_q, 2'h0, trig_rise_sel_q};
        `PTC_OFF_CTRL1: rdata_q <= {ctrl_q[6:2], ctrl_q[1], 1'b0, ctrl_q[0]};
        `PTC_OFF_CMPA_LO: rdata_q <= compare_a_value_q[7:0];
        `PTC_OFF_CMPA_HI: rdata_q <= {6'h00, compare_a_value_q[9:8]};
        `PTC_OFF_PER_LO: rdata_q <= period_value_q[7:0];
        `PTC_OFF_PER_HI: rdata_q <= {6'h00, period_value_q[9:8]};
        `PTC_OFF_STATUS: rdata_q <= {cnt_q[9:8], 4'h0, pf_q, af_q};
        default: rdata_q <= cnt_q[7:0];
      endcase
    end
  end

  assign rdata = rdata_q;
  assign out_pin = out_q;
  assign out_oe = oe_q;
  assign compare_a_flag = af_q;
  assign period_match_flag = pf_q;
endmodule

// ==== test/ptc_checker.sv ====
// Port checker for the periodic timer.
// Assumes a bind to ptc_timer; ctrl1 is shadowed from register writes.
`timescale 1ns/10ps
module ptc_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire ptc_pkg::ptc_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic tick_en,
  input wire logic out_oe,
  input wire logic compare_a_flag,
  input wire logic period_match_flag
);
  import ptc_pkg::*;
  logic [7:0] c1_q;
  logic st_wr;
  assign st_wr = bus.wr && bus.addr == 3'h6;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      c1_q <= 8'h00;
    else if (bus.wr && bus.addr == 3'h1)
      c1_q <= bus.wdata;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  oe_mode_a: assert property (
    $past(rst_n) && $stable(c1_q) |-> out_oe == (c1_q[7:6] != 2'h3))
    else $error("out_oe wrong");
  hi_zero_a: assert property (
    bus.rd && (bus.addr == 3'h3 || bus.addr == 3'h5) |=> rdata[7:2] == 6'h00)
    else $error("high byte bits set");
  rd_hold_a: assert property (!$past(bus.rd) |-> $stable(rdata))
    else $error("rdata moved");
  a_tick_a: assert property ($rose(compare_a_flag) |-> $past(tick_en))
    else $error("flag without tick");
  p_clrsel_a: assert property (
    $rose(period_match_flag) |-> !($past(c1_q[0]) && $past(c1_q[7:6]) == 2'h0))
    else $error("period flag with clear select");
  a_hold_a: assert property (
    compare_a_flag && !(st_wr && bus.wdata[0]) |=> compare_a_flag)
    else $error("a flag lost");
  p_hold_a: assert property (
    period_match_flag && !(st_wr && bus.wdata[1]) |=> period_match_flag)
    else $error("p flag lost");
  a_clear_a: assert property (
    st_wr && bus.wdata[0] && !tick_en |=> !compare_a_flag)
    else $error("a flag not cleared");
endmodule

// ==== test/tb.sv ====
// Bench for the periodic timer: register tasks and mode scenarios.
// Assumes ptc_timer and ptc_checker are compiled before it.
`timescale 1ns/10ps
module tb;
  import ptc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  ptc_bus_t bus = '0;
  logic tick_en = 1'b0;
  logic trig_pin = 1'b0;
  logic [7:0] rdata;
  logic out_pin, out_oe, compare_a_flag, period_match_flag;
  logic [7:0] r;
  logic [23:0] pw [5] = '{24'hA8030C, 24'hA80920, 24'hAC0314, 24'h980020, 24'h880300};
  int error_cnt = 0;
  int n_tests = 0;
  int h;
  ptc_timer dut_u (.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .tick_en(tick_en), .trig_pin(trig_pin), .out_pin(out_pin), .out_oe(out_oe),
    .compare_a_flag(compare_a_flag), .period_match_flag(period_match_flag));
  initial forever #20 core_clk = ~core_clk;
  // Half-rate ticks, so a match that ignores tick_en shows up
  always @(posedge core_clk) tick_en <= ~tick_en;
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge core_clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk);
    bus <= '0;
    #1 r = rdata;
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Mode bits must only change while stopped
  task automatic setup(input logic [7:0] c1, input logic [7:0] ca, input logic [7:0] pr);
    wr(3'h0, 8'h00);
    wr(3'h1, c1);
    wr(3'h2, ca);
    wr(3'h4, pr);
    wr(3'h6, 8'h03);
    wr(3'h0, 8'h08);
  endtask
  task automatic cnt_hi(output int c);
    c = 0;
    repeat (32) begin
      @(posedge core_clk);
      #1 c += (out_pin === 1'b1);
    end
  endtask
  initial begin
    run(5);
    rst_n <= 1'b1;
    for (int a = 2; a < 6; a++) begin
      rd(a[2:0]);
      chk("reg reset", r, 8'h00);
    end
    wr(3'h3, 8'hFF);
    wr(3'h5, 8'hFE);
    wr(3'h4, 8'hA5);
    rd(3'h3);
    chk("cmpa_hi", r, 8'h03);
    rd(3'h5);
    chk("per_hi", r, 8'h02);
    rd(3'h4);
    chk("per_lo", r, 8'hA5);
    wr(3'h3, 8'h00);
    wr(3'h5, 8'h00);
    $display("Test registers done");
    setup(8'h18, 8'h03, 8'h05);
    run(3);
    chk("init level", 8'(out_pin), 8'h01);
    run(60);
    chk("cmp pin", 8'(out_pin), 8'h00);
    chk("cmp flags", 8'({compare_a_flag, period_match_flag}), 8'h03);
    setup(8'h08, 8'h03, 8'h05);
    run(60);
    chk("no change", 8'(out_pin), 8'h01);
    setup(8'h30, 8'h03, 8'h05);
    cnt_hi(h);
    chk("toggle", 8'(h > 2 && h < 30), 8'h01);
    setup(8'h21, 8'h06, 8'h02);
    run(60);
    chk("clr sel", 8'({compare_a_flag, period_match_flag}), 8'h02);
    setup(8'h20, 8'h00, 8'h05);
    run(60);
    chk("cmpa zero", 8'({compare_a_flag, period_match_flag}), 8'h01);
    setup(8'hC0, 8'h03, 8'h05);
    run(60);
    chk("timer", 8'({out_oe, compare_a_flag, period_match_flag}), 8'h03);
    $display("Test compare done");
    foreach (pw[i]) begin
      setup(pw[i][23:16], pw[i][15:8], 8'h08);
      run(8);
      cnt_hi(h);
      chk("pwm high", 8'(h), pw[i][7:0]);
    end
    chk("forced flags", 8'({compare_a_flag, period_match_flag}), 8'h03);
    $display("Test pwm done");
    setup(8'hB8, 8'h10, 8'h02);
    run(10);
    chk("sw pulse", 8'(out_pin), 8'h01);
    run(80);
    rd(3'h0);
    chk("pulse end", 8'({r[3], compare_a_flag, out_pin}), 8'h02);
    rd(3'h7);
    h = r;
    run(20);
    rd(3'h7);
    chk("cnt hold", r, 8'(h));
    wr(3'h0, 8'h01);
    trig_pin <= 1'b1;
    run(10);
    chk("trig pulse", 8'(out_pin), 8'h01);
    run(80);
    chk("trig end", 8'(out_pin), 8'h00);
    wr(3'h0, 8'h00);
    trig_pin <= 1'b0;
    run(10);
    chk("fall trig", 8'(out_pin), 8'h01);
    $display("Test pulse done");
    give_verdict();
  end
endmodule
bind ptc_timer ptc_checker chk_u (.core_clk(core_clk), .rst_n(rst_n), .bus(bus),
  .rdata(rdata), .tick_en(tick_en), .out_oe(out_oe), .compare_a_flag(compare_a_flag),
  .period_match_flag(period_match_flag));
